/* include/ipos_pkg.sv */
// Constants for the interrupt pin output stage
// Functional notes
// - After reset the pin is low active, low while pending and high otherwise.
// - Writing the polarity bit to 1 makes high the pending level.
// - Setting the weak-drive enable to 1 turns plain driving into shared-line drive.
// - Weak-drive on with wired-AND select at its reset value 0 gives wired-OR.
// - Wired-OR drives inactive weakly when idle and active strongly.
// - Wired-AND drives the inactive level strongly when nothing is pending.
// - Wired-AND drives the active level only weakly while pending.
// - The interrupt is the OR of all events whose select bit is set.
// - Reading the event register clears it automatically.
// - Events with a clear-exception bit survive reads; write 1 clears them.
package ipos_pkg;
    localparam int IPOS_DW = 32;
    localparam int IPOS_AW = 4;
    localparam logic [3:0] IPOS_OFS_CONFIG = 4'h0;
    localparam logic [3:0] IPOS_OFS_CLR_EXC = 4'h3;
    localparam logic [3:0] IPOS_OFS_MASK = 4'h4;
    localparam logic [3:0] IPOS_OFS_EVENTS = 4'h5;
    localparam logic [3:0] IPOS_OFS_STATUS = 4'h6;
    localparam int IPOS_BIT_POL = 29;
    localparam int IPOS_BIT_WEAK_EN = 15;
    localparam int IPOS_BIT_WIRED_AND = 30;
    localparam logic [31:0] IPOS_RST_CONFIG = 32'h0000_0000;
    localparam logic [31:0] IPOS_RST_WORD = 32'h0000_0000;
endpackage

/* verilog/ipos_pin_drive.sv */
// Pin driver for polarity and weak/strong drive
`timescale 1ns/10ps
module ipos_pin_drive (
    input wire logic pending,
    input wire logic pol_high,
    input wire logic weak_en,
    input wire logic wired_and,
    output logic pin_level,
    output logic pin_strong
);
    always_comb begin
        pin_level = pending ~^ pol_high;
        if (!weak_en) begin
            pin_strong = 1'b1;
        end else if (!wired_and) begin
            pin_strong = pending;
        end else begin
            pin_strong = ~pending;
        end
    end
endmodule // ipos_pin_drive

/* verilog/ipos_irq_out.sv */
// Interrupt output stage with Avalon-MM register slave
`timescale 1ns/10ps
module ipos_irq_out
    import ipos_pkg::*;
#(
    parameter int EVW = 32
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [ipos_pkg::IPOS_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ipos_pkg::IPOS_DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [ipos_pkg::IPOS_DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [EVW-1:0] event_set,
    output logic irq_pin_level,
    output logic irq_pin_strong,
    output logic irq_pin_oe
);
    import ipos_pkg::*;

    logic [31:0] config_q, config_d;
    logic [EVW-1:0] exc_q, exc_d, mask_q, mask_d, ev_q, ev_d;
    logic [31:0] rdata_q, rdata_d;
    logic ack_q, ack_d;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic pending;
    logic general_config_pol, irq_weak_drive_enable, irq_wired_and_select;
    logic req_first;
    logic req_commit;
    logic [EVW-1:0] rd_clr;
    logic [EVW-1:0] rd_fresh;
    logic [EVW-1:0] ev_keep;
    logic [EVW-1:0] wr_clr;
    logic wr_pol;
    logic wr_weak;
    logic wr_wand;

    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wval = avs_writedata & wmask;
    assign general_config_pol = config_q[IPOS_BIT_POL];
    assign irq_weak_drive_enable = config_q[IPOS_BIT_WEAK_EN];
    assign irq_wired_and_select = config_q[IPOS_BIT_WIRED_AND];
    assign pending = |(ev_q & mask_q);
    // First cycle loads read data, second cycle commits side effects
    assign req_first = (avs_read | avs_write) & ~ack_q;
    assign req_commit = (avs_read | avs_write) & ack_q;
    assign avs_waitrequest = req_first;
    // Only reported, non-excepted events are cleared by a read
    assign rd_clr = rdata_q[EVW-1:0] & ~exc_q;
    assign rd_fresh = rd_clr & ~event_set;
    assign ev_keep = ev_q & exc_q;
    assign wr_clr = avs_writedata[EVW-1:0] & ~event_set;
    assign wr_pol = avs_writedata[IPOS_BIT_POL];
    assign wr_weak = avs_writedata[IPOS_BIT_WEAK_EN];
    assign wr_wand = avs_writedata[IPOS_BIT_WIRED_AND];
    assign avs_readdata = rdata_q;
    assign irq_pin_oe = 1'b1;

    always_comb begin
        logic [31:0] rd;
        rd = 32'h0000_0000;
        config_d = config_q;
        exc_d = exc_q;
        mask_d = mask_q;
        ev_d = ev_q;
        ack_d = req_first;
        rdata_d = rdata_q;
        if (req_commit && avs_write) begin
            unique case (avs_address)
                IPOS_OFS_CONFIG: config_d = (config_q & ~wmask) | wval;
                IPOS_OFS_CLR_EXC:
                    exc_d = EVW'((32'(exc_q) & ~wmask) | wval);
                IPOS_OFS_MASK:
                    mask_d = EVW'((32'(mask_q) & ~wmask) | wval);
                IPOS_OFS_EVENTS: ev_d = ev_q & ~EVW'(wval);
                default: ;
            endcase
        end
        if (req_first && avs_read) begin
            unique case (avs_address)
                IPOS_OFS_CONFIG: rd = config_q;
                IPOS_OFS_CLR_EXC: rd = 32'(exc_q);
                IPOS_OFS_MASK: rd = 32'(mask_q);
                IPOS_OFS_EVENTS: rd = 32'(ev_q);
                IPOS_OFS_STATUS: rd = {31'h0000_0000, pending};
                default: rd = 32'h0000_0000;
            endcase
            rdata_d = rd;
        end
        if (req_commit && avs_read && avs_address == IPOS_OFS_EVENTS) begin
            ev_d = ev_q & ~rd_clr;
        end
        ev_d = ev_d | event_set;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            config_q <= IPOS_RST_CONFIG;
            exc_q <= '0;
            mask_q <= '0;
            ev_q <= '0;
            ack_q <= 1'b0;
            rdata_q <= IPOS_RST_WORD;
        end else begin
            config_q <= config_d;
            exc_q <= exc_d;
            mask_q <= mask_d;
            ev_q <= ev_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    ipos_pin_drive u_drive (
        .pending(pending),
        .pol_high(general_config_pol),
        .weak_en(irq_weak_drive_enable),
        .wired_and(irq_wired_and_select),
        .pin_level(irq_pin_level),
        .pin_strong(irq_pin_strong)
    );

    chk_pol_level: assert property (@(posedge clk) disable iff (!rst_b)
        irq_pin_level == (pending ~^ general_config_pol))
        else $error("pin level wrong");
    chk_reset_idle: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> irq_pin_level)
        else $error("pin not idle high after reset");
    chk_plain_strong: assert property (@(posedge clk) disable iff (!rst_b)
        !irq_weak_drive_enable |-> irq_pin_strong)
        else $error("plain drive not strong");
    chk_wor_drive: assert property (@(posedge clk) disable iff (!rst_b)
        irq_weak_drive_enable && !irq_wired_and_select
        |-> irq_pin_strong == pending)
        else $error("wired-or strength wrong");
    chk_wand_drive: assert property (@(posedge clk) disable iff (!rst_b)
        irq_weak_drive_enable && irq_wired_and_select
        |-> irq_pin_strong != pending)
        else $error("wired-and strength wrong");
    chk_event_sticky: assert property (@(posedge clk) disable iff (!rst_b)
        event_set[0] |=> ev_q[0])
        else $error("event lost");
    chk_read_clear: assert property (@(posedge clk) disable iff (!rst_b)
        avs_read && ack_q && avs_address == IPOS_OFS_EVENTS
        |=> (ev_q & $past(rd_fresh)) == '0)
        else $error("event not cleared by read");
    chk_read_keep: assert property (@(posedge clk) disable iff (!rst_b)
        avs_read && ack_q && avs_address == IPOS_OFS_EVENTS
        |=> (ev_q & $past(ev_keep)) == $past(ev_keep))
        else $error("excepted event cleared by read");
    chk_or_mask: assert property (@(posedge clk) disable iff (!rst_b)
        (|(ev_q & mask_q)) == pending)
        else $error("pending mismatch");

    sequence s_req_first;
        req_first;
    endsequence
    sequence s_wr_commit;
        req_commit && avs_write && avs_byteenable == 4'hf;
    endsequence
    sequence s_rd_status;
        req_first && avs_read && avs_address == IPOS_OFS_STATUS;
    endsequence

    chk_one_wait: assert property (@(posedge clk) disable iff (!rst_b)
        s_req_first |=> !avs_waitrequest)
        else $error("more than one wait cycle");
    chk_ack_single: assert property (@(posedge clk) disable iff (!rst_b)
        ack_q |=> !ack_q)
        else $error("acknowledge held too long");
    chk_cfg_write: assert property (@(posedge clk) disable iff (!rst_b)
        s_wr_commit ##0 avs_address == IPOS_OFS_CONFIG
        |=> general_config_pol == $past(wr_pol)
        && irq_weak_drive_enable == $past(wr_weak)
        && irq_wired_and_select == $past(wr_wand))
        else $error("config write lost");
    chk_ev_write_clr: assert property (@(posedge clk) disable iff (!rst_b)
        s_wr_commit ##0 avs_address == IPOS_OFS_EVENTS
        |=> (ev_q & $past(wr_clr)) == '0)
        else $error("event not cleared by write");
    chk_status_read: assert property (@(posedge clk) disable iff (!rst_b)
        s_rd_status |=> avs_readdata[0] == $past(pending)
        && avs_readdata[31:1] == 31'h0000_0000)
        else $error("status read wrong");
    chk_reset_cfg: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> !general_config_pol && !irq_wired_and_select
        && !irq_weak_drive_enable)
        else $error("config not at reset value");
    chk_active_level: assert property (@(posedge clk) disable iff (!rst_b)
        pending |-> irq_pin_level == general_config_pol)
        else $error("active level wrong");
    chk_idle_level: assert property (@(posedge clk) disable iff (!rst_b)
        !pending |-> irq_pin_level != general_config_pol)
        else $error("idle level wrong");
    chk_wor_idle: assert property (@(posedge clk) disable iff (!rst_b)
        irq_weak_drive_enable && !irq_wired_and_select && !pending
        |-> !irq_pin_strong)
        else $error("wired-or idle not weak");
    chk_wor_active: assert property (@(posedge clk) disable iff (!rst_b)
        irq_weak_drive_enable && !irq_wired_and_select && pending
        |-> irq_pin_strong)
        else $error("wired-or active not strong");
    chk_wand_idle: assert property (@(posedge clk) disable iff (!rst_b)
        irq_weak_drive_enable && irq_wired_and_select && !pending
        |-> irq_pin_strong)
        else $error("wired-and idle not strong");
    chk_wand_pend: assert property (@(posedge clk) disable iff (!rst_b)
        irq_weak_drive_enable && irq_wired_and_select && pending
        |-> !irq_pin_strong)
        else $error("wired-and active not weak");
    chk_pin_driven: assert property (@(posedge clk) disable iff (!rst_b)
        irq_pin_oe)
        else $error("pin not driven");
endmodule // ipos_irq_out

/* bench/ipos_host_model.sv */
// Host interrupt input on a line shared with one more device
`timescale 1ns/10ps
module ipos_host_model (
    input wire logic lvl_a,
    input wire logic str_a,
    input wire logic lvl_b,
    input wire logic str_b,
    output logic line
);
    always_comb begin
        if (str_a && str_b && lvl_a != lvl_b) line = 1'bx;
        else if (str_a) line = lvl_a;
        else if (str_b) line = lvl_b;
        else line = (lvl_a == lvl_b) ? lvl_a : 1'bx;
    end
endmodule // ipos_host_model

/* bench/ipos_irq_out_bench.sv */
// Self-checking bench for the interrupt pin output stage
`timescale 1ns/10ps
module ipos_irq_out_bench;
    import ipos_pkg::*;
    logic clk = 0, rst_b = 0, avs_read = 0, avs_write = 0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = '0, event_set = '0, avs_readdata, e, eb, en, d;
    logic avs_waitrequest, lvl, str, oe, line, pol = 0, wk = 0, wa = 0;
    logic [31:0] exp_q[$];
    int mismatches = 0, checks_done = 0, b;
    always #5 clk = ~clk;
    ipos_irq_out dut_u (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_waitrequest(avs_waitrequest), .event_set(event_set),
        .irq_pin_level(lvl), .irq_pin_strong(str), .irq_pin_oe(oe));
    ipos_host_model host_u (.lvl_a(lvl), .str_a(str), .lvl_b(~pol),
        .str_b(~wk | wa), .line(line));
    task automatic fail(input string m);
        mismatches++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] v);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= v;
        avs_read <= !w;
        avs_write <= w;
        @(posedge clk);
        while (avs_waitrequest) @(posedge clk);
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] v);
        exp_q.push_back(v);
        bus(0, a, '0);
    endtask
    always @(posedge clk) if (avs_read && !avs_waitrequest) begin
        checks_done++;
        e = exp_q.pop_front();
        if (avs_readdata !== e) fail("read data");
    end
    task automatic ev(input logic [31:0] v);
        @(posedge clk);
        event_set <= v;
        @(posedge clk);
        event_set <= '0;
    endtask
    task automatic pin(input logic p);
        checks_done++;
        if (lvl !== (pol ? p : ~p) || oe !== 1'b1) fail("pin level");
        if (str !== (~wk | (wa ? ~p : p))) fail("pin strength");
        if (wk && line !== ((p && !wa) ? pol : ~pol)) fail("shared line");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        fail("timeout");
        summarize();
    end
    initial begin
        b = $urandom(50) % 32;
        eb = 32'h0000_0001 << b;
        en = 32'h0000_0001 << ((b + 1) % 32);
        repeat (12) @(posedge clk);
        rst_b <= 1;
        #1 pin(0);
        rd(IPOS_OFS_STATUS, '0);
        bus(1, IPOS_OFS_MASK, eb);
        ev(en);
        #1 pin(0);
        ev(eb);
        #1 pin(1);
        rd(IPOS_OFS_EVENTS, eb | en);
        #1 pin(0);
        bus(1, IPOS_OFS_CLR_EXC, eb);
        ev(eb);
        rd(IPOS_OFS_EVENTS, eb);
        #1 pin(1);
        bus(1, IPOS_OFS_EVENTS, eb);
        #1 pin(0);
        for (int m = 0; m < 8; m++) begin
            {wa, wk, pol} = m[2:0];
            d = '0;
            d[IPOS_BIT_POL] = pol;
            d[IPOS_BIT_WEAK_EN] = wk;
            d[IPOS_BIT_WIRED_AND] = wa;
            bus(1, IPOS_OFS_CONFIG, d);
            #1 pin(0);
            ev(eb);
            #1 pin(1);
            bus(1, IPOS_OFS_EVENTS, eb);
        end
        rd(4'h7, '0);
        summarize();
    end
endmodule // ipos_irq_out_bench
